//--- hw/rhs_pkg.sv
/*
 * Constants, field layouts and carrier types for the root hub global status block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package rhs_pkg;
  // The command codes double as byte addresses on the bus.
  localparam logic [7:0] RHS_RD_CODE = 8'h14;
  localparam logic [7:0] RHS_WR_CODE = 8'h94;
  localparam logic [7:0] RHS_CTRL_ADDR = 8'h40;
  localparam logic [7:0] RHS_PWR_ADDR = 8'h44;
  localparam logic [7:0] RHS_IRQ_STAT_ADDR = 8'h48;
  localparam logic [7:0] RHS_IRQ_MASK_ADDR = 8'h4c;
  localparam int RHS_ADR_W = 8;
  localparam int RHS_DAT_W = 32;
  localparam int RHS_SEL_W = 4;

  // Global status register fields.
  localparam int RHS_CLR_WAKE_BIT = 31;
  localparam int RHS_OC_CHANGE_BIT = 17;
  localparam int RHS_SET_PWR_BIT = 16;
  localparam int RHS_WAKE_EN_BIT = 15;
  localparam int RHS_OC_IND_BIT = 1;
  localparam int RHS_CLR_PWR_BIT = 0;

  // Control register fields.
  localparam int RHS_SCHEME_BIT = 0;
  localparam int RHS_PER_PORT_OC_BIT = 1;
  localparam int RHS_MASK_LSB = 16;
  localparam int RHS_MASK_W = 3;

  // Interrupt status and mask fields.
  localparam int RHS_IRQ_OC_BIT = 0;
  localparam int RHS_IRQ_RESUME_BIT = 1;
  localparam int RHS_IRQ_W = 2;

  localparam logic [31:0] RHS_RESET_VAL = 32'h00000000;
  localparam logic [31:0] RHS_UNMAPPED_VAL = 32'h00000000;

  typedef struct packed {
    logic [RHS_MASK_W-1:0] port_power_mask_field;
    logic per_port_oc;
    logic power_switch_scheme;
  } rhs_ctrl_t;

  typedef struct packed {
    logic remote_wake_enable;
    logic overcurrent_change_flag;
    logic overcurrent_indicator;
  } rhs_stat_t;
endpackage : rhs_pkg

//--- hw/rhs_root_hub_status.sv
/*
 * Root hub global status and control register with a classic Wishbone slave,
 * global power commands, remote wake-up enable and global overcurrent reporting.
 * Assumes all inputs are synchronous to sys_clk except overcurrent_in, which is
 * synchronised here, and that per-port power commands arrive as one-cycle pulses.
 */
// Register access over Wishbone is this design's own decision.
// Summary of operation
// [R01] Register reads at code 14 hex, accepts writes at code 94 hex.
// [R02] Low half holds hub status bits, high half holds change bits.
// [R03] Software writes zero into every reserved bit position.
// [R04] Writing one to bit 31 clears wake enable; zero does nothing.
// [R05] Overcurrent change flag in bit 17 sets when the indicator changes.
// [R06] Overcurrent change flag clears only by writing one to it.
// [R07] Bits 16 and 0 always read zero.
// [R08] Global mode: one to bit 16 powers all ports on.
// [R09] Per-port mode: one to bit 16 powers unmasked ports on.
// [R10] Global mode: one to bit 0 powers all ports off.
// [R11] Per-port mode: one to bit 0 powers unmasked ports off.
// [R12] With wake enable, attach change in suspend resumes and raises interrupt.
// [R13] Writing one to bit 15 sets wake enable; zero does nothing.
// [R14] Global reporting: bit 1 reads one during overcurrent, zero otherwise.
// [R15] Per-port overcurrent protection makes bit 1 read zero always.
// [R16] Per-port mode: masked ports follow only per-port commands; unmasked follow global ones.
// [R17] Implemented bits reset to zero; overcurrent input synchronised first.
`timescale 1ns/100ps
module rhs_root_hub_status
  import rhs_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [RHS_ADR_W-1:0] wb_adr_i,
  input wire logic [RHS_SEL_W-1:0] wb_sel_i,
  input wire logic [RHS_DAT_W-1:0] wb_dat_i,
  output logic [RHS_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic overcurrent_in,
  input wire logic bus_suspended,
  input wire logic [NPORTS:1] port_attach_change,
  input wire logic [NPORTS:1] port_power_set,
  input wire logic [NPORTS:1] port_power_clr,
  output logic [NPORTS:1] port_power_on,
  output logic resume_request,
  output logic irq
);

  // Mask position 0 is reserved, so the mask field serves at most two ports.
  if (NPORTS < 1 || NPORTS > RHS_MASK_W - 1) begin : g_bad_nports
    $error("NPORTS must be 1 or 2");
  end

  logic wb_ack_ff;
  logic nxt_wb_ack;
  logic [RHS_DAT_W-1:0] wb_dat_ff;
  logic [RHS_DAT_W-1:0] nxt_wb_dat;

  rhs_ctrl_t ctrl_ff;
  rhs_ctrl_t nxt_ctrl;
  rhs_stat_t stat_ff;
  rhs_stat_t nxt_stat;

  logic oc_meta_ff;
  logic oc_sync_ff;
  logic [NPORTS:1] pwr_ff;
  logic [NPORTS:1] nxt_pwr;
  logic resume_ff;
  logic nxt_resume;

  logic [RHS_IRQ_W-1:0] irq_stat_ff;
  logic [RHS_IRQ_W-1:0] nxt_irq_stat;
  logic [RHS_IRQ_W-1:0] irq_mask_ff;
  logic [RHS_IRQ_W-1:0] nxt_irq_mask;
  logic irq_ff;
  logic nxt_irq;

  logic req;
  logic wr;
  logic rd;
  logic [RHS_DAT_W-1:0] bmask;
  logic [RHS_DAT_W-1:0] wdat;
  logic wr_stat;
  logic oc_now;
  logic oc_evt;
  logic resume_evt;
  logic [NPORTS:1] unmasked;

  // A request is taken at the first edge that sees it and answered one cycle later.
  // Masking with the registered ack keeps a held strobe from being taken twice,
  // so every write lands once, at the edge that raises ack.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  // Byte enables gate the write data, so a command bit in a disabled lane has no effect.
  always_comb begin
    for (int i = 0; i < RHS_SEL_W; i++) begin
      bmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  assign wdat = wb_dat_i & bmask;
  assign wr_stat = wr && (wb_adr_i == RHS_WR_CODE); // [R01]
  // This holds the mask bits: in the per-port scheme a set bit hands the port to per-port commands,
  // a clear bit leaves it under the global set and clear commands.
  assign unmasked = ctrl_ff.port_power_mask_field[NPORTS:1];

  // Per-port reporting forces the global indicator to zero.
  assign oc_now = oc_sync_ff & ~ctrl_ff.per_port_oc; // [R14] [R15]
  assign oc_evt = oc_now != stat_ff.overcurrent_indicator; // [R05]
  assign resume_evt = stat_ff.remote_wake_enable & bus_suspended
                      & (|port_attach_change); // [R12]

  // Bus answer and read data.
  // Unmapped addresses are acknowledged and read as zero.
  always_comb begin
    nxt_wb_ack = req;
    nxt_wb_dat = RHS_UNMAPPED_VAL;
    if (rd) begin
      case (wb_adr_i)
        RHS_RD_CODE: begin // [R01]
          // Bits 31, 16 and 0 are command bits and read back as zero.
          nxt_wb_dat = RHS_RESET_VAL; // [R07]
          nxt_wb_dat[RHS_OC_CHANGE_BIT] = stat_ff.overcurrent_change_flag; // [R02]
          nxt_wb_dat[RHS_WAKE_EN_BIT] = stat_ff.remote_wake_enable; // [R02]
          nxt_wb_dat[RHS_OC_IND_BIT] = stat_ff.overcurrent_indicator; // [R02]
        end
        RHS_CTRL_ADDR: begin
          nxt_wb_dat[RHS_SCHEME_BIT] = ctrl_ff.power_switch_scheme;
          nxt_wb_dat[RHS_PER_PORT_OC_BIT] = ctrl_ff.per_port_oc;
          nxt_wb_dat[RHS_MASK_LSB +: RHS_MASK_W] = ctrl_ff.port_power_mask_field;
        end
        RHS_PWR_ADDR: begin
          nxt_wb_dat[NPORTS:1] = pwr_ff;
        end
        RHS_IRQ_STAT_ADDR: begin
          nxt_wb_dat[RHS_IRQ_W-1:0] = irq_stat_ff;
        end
        RHS_IRQ_MASK_ADDR: begin
          nxt_wb_dat[RHS_IRQ_W-1:0] = irq_mask_ff;
        end
        default: begin
          nxt_wb_dat = RHS_UNMAPPED_VAL;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= RHS_RESET_VAL;
    end else begin
      wb_ack_ff <= nxt_wb_ack;
      wb_dat_ff <= nxt_wb_dat;
    end
  end

  // Control register: switching scheme, overcurrent reporting, power mask.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr && (wb_adr_i == RHS_CTRL_ADDR)) begin
      if (wb_sel_i[0]) begin
        nxt_ctrl.power_switch_scheme = wdat[RHS_SCHEME_BIT];
        // Changing the reporting mode moves the indicator and can raise a change event.
        nxt_ctrl.per_port_oc = wdat[RHS_PER_PORT_OC_BIT];
      end
      if (wb_sel_i[2]) begin
        nxt_ctrl.port_power_mask_field = wdat[RHS_MASK_LSB +: RHS_MASK_W];
        // Position 0 of the mask has no port behind it.
        nxt_ctrl.port_power_mask_field[0] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= '0; // [R17]
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Overcurrent synchroniser; only the second stage feeds the logic.
  // The indicator therefore lags the pin by three edges.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oc_meta_ff <= 1'b0;
      oc_sync_ff <= 1'b0;
    end else begin
      oc_meta_ff <= overcurrent_in; // [R17]
      oc_sync_ff <= oc_meta_ff; // [R17]
    end
  end

  // Global status bits; a hardware set wins over a software clear.
  always_comb begin
    nxt_stat = stat_ff;
    nxt_stat.overcurrent_indicator = oc_now; // [R14]
    if (wr_stat && wdat[RHS_OC_CHANGE_BIT]) begin
      nxt_stat.overcurrent_change_flag = 1'b0; // [R06]
    end
    if (oc_evt) begin
      nxt_stat.overcurrent_change_flag = 1'b1; // [R05]
    end
    if (wr_stat && wdat[RHS_WAKE_EN_BIT]) begin
      nxt_stat.remote_wake_enable = 1'b1; // [R13]
    end
    // The clear comes last, so it wins when bits 31 and 15 are written together.
    if (wr_stat && wdat[RHS_CLR_WAKE_BIT]) begin
      nxt_stat.remote_wake_enable = 1'b0; // [R04]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff <= '0; // [R17]
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Port power: global commands first, then per-port commands of masked ports.
  always_comb begin
    nxt_pwr = pwr_ff;
    if (wr_stat && wdat[RHS_SET_PWR_BIT]) begin
      if (!ctrl_ff.power_switch_scheme) begin
        nxt_pwr = '1; // [R08]
      end else begin
        nxt_pwr = pwr_ff | ~unmasked; // [R09] [R16]
      end
    end
    // The clear follows the set, so a write of both leaves the affected ports off.
    if (wr_stat && wdat[RHS_CLR_PWR_BIT]) begin
      if (!ctrl_ff.power_switch_scheme) begin
        nxt_pwr = '0; // [R10]
      end else begin
        nxt_pwr = nxt_pwr & unmasked; // [R11] [R16]
      end
    end
    // Per-port pulses reach only masked ports and only in the per-port scheme;
    // a clear pulse beats a set pulse on the same port.
    if (ctrl_ff.power_switch_scheme) begin
      nxt_pwr = (nxt_pwr | (port_power_set & unmasked))
                & ~(port_power_clr & unmasked); // [R16]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_ff <= '0; // [R17]
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // Interrupt status, mask and output.
  always_comb begin
    // The resume request is a one-cycle pulse for each qualifying attach change.
    nxt_resume = resume_evt; // [R12]
    nxt_irq_mask = irq_mask_ff;
    if (wr && (wb_adr_i == RHS_IRQ_MASK_ADDR) && wb_sel_i[0]) begin
      nxt_irq_mask = wdat[RHS_IRQ_W-1:0];
    end
    nxt_irq_stat = irq_stat_ff;
    // A read clears the status, but an event in the same cycle still sets its bit.
    if (rd && (wb_adr_i == RHS_IRQ_STAT_ADDR)) begin
      nxt_irq_stat = '0;
    end
    if (oc_evt) begin
      nxt_irq_stat[RHS_IRQ_OC_BIT] = 1'b1;
    end
    if (resume_evt) begin
      nxt_irq_stat[RHS_IRQ_RESUME_BIT] = 1'b1; // [R12]
    end
    // Built from the next values, the output moves at the same edge as the status.
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      resume_ff <= 1'b0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      resume_ff <= nxt_resume;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
    end
  end

  // Every output is taken straight from a flip-flop.
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign port_power_on = pwr_ff;
  assign resume_request = resume_ff;
  assign irq = irq_ff;

endmodule : rhs_root_hub_status

//--- test/rhs_chk.sv
/* Port checker for the root hub status block.
   Bound to rhs_root_hub_status in the bench; sees only its ports. */
`timescale 1ns/100ps
module rhs_chk
  import rhs_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [RHS_ADR_W-1:0] wb_adr_i,
  input wire logic [RHS_SEL_W-1:0] wb_sel_i,
  input wire logic [RHS_DAT_W-1:0] wb_dat_i,
  input wire logic [RHS_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic overcurrent_in,
  input wire logic bus_suspended,
  input wire logic [NPORTS:1] port_attach_change,
  input wire logic [NPORTS:1] port_power_set,
  input wire logic [NPORTS:1] port_power_clr,
  input wire logic [NPORTS:1] port_power_on,
  input wire logic resume_request,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_zeros: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == RHS_RD_CODE)
    |-> (wb_dat_o & ~32'h00028002) == 32'h0) else $error("status bit not zero");
  a_power_cause: assert property (
    $changed(port_power_on) |-> (wb_ack_o && $past(wb_we_i))
    || $past(|(port_power_set | port_power_clr))) else $error("power moved alone");
  a_resume_cause: assert property (
    resume_request
    |-> $past(bus_suspended && |port_attach_change)) else $error("stray resume");
  // Pin to read data: two sync stages, the status register, then the registered answer.
  a_oc_cause: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == RHS_RD_CODE)
    && wb_dat_o[1] |-> $past(overcurrent_in, 4)) else $error("stray indicator");
  // A control write that flips the reporting mode raises irq one edge after its ack.
  a_irq_cause: assert property (
    $rose(irq) |-> resume_request || wb_ack_o || $past(wb_ack_o)
    || $past(overcurrent_in, 5) != $past(overcurrent_in, 3)) else $error("stray irq");
  c_resume: cover property (resume_request);
  c_irq: cover property ($rose(irq));
  c_power: cover property (port_power_on == '1);
endmodule : rhs_chk

//--- test/tb.sv
/* Self-checking bench for the root hub status block.
   Drives classic Wishbone cycles and side pins; the checker is bound below. */
`timescale 1ns/100ps
module tb;
  import rhs_pkg::*;
  localparam int NP = 2;
  localparam logic [7:0] RD = RHS_RD_CODE;
  localparam logic [7:0] WR = RHS_WR_CODE;
  localparam logic [7:0] PW = RHS_PWR_ADDR;
  localparam logic [7:0] ST = RHS_IRQ_STAT_ADDR;
  logic sys_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, oc = 0, susp = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic [NP:1] att = '0, pset = '0, pclr = '0, pon;
  logic ack, resume, irq;
  int n_mismatch = 0, comparisons = 0, cycles = 0;

  rhs_root_hub_status #(.NPORTS(NP)) DUT (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .overcurrent_in(oc), .bus_suspended(susp),
    .port_attach_change(att), .port_power_set(pset), .port_power_clr(pclr),
    .port_power_on(pon), .resume_request(resume), .irq(irq));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One classic cycle; ack and read data are taken at the rising edge that sees ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge sys_clk); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(got, e);
  endtask : rd

  task automatic pulse(input int k, input logic [NP:1] v);
    @(posedge sys_clk);
    if (k == 0) att <= v;
    else if (k == 1) pset <= v;
    else pclr <= v;
    @(posedge sys_clk);
    att <= '0;
    pset <= '0;
    pclr <= '0;
    @(negedge sys_clk);
  endtask : pulse

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(RD, RHS_RESET_VAL);
    rd(PW, 32'h0);
    rd(8'h80, RHS_UNMAPPED_VAL);
    $display("reset test done");
    wr(WR, 32'h8000);
    rd(RD, 32'h8000);
    wr(WR, 32'h0);
    rd(RD, 32'h8000);
    wr(RD, 32'h80000000);
    rd(RD, 32'h8000);
    rd(WR, 32'h0);
    wr(WR, 32'h80000000);
    rd(RD, 32'h0);
    bus(1'b1, WR, 32'h00018000, 4'h2);
    rd(RD, 32'h8000);
    rd(PW, 32'h0);
    wr(WR, 32'h80000000);
    rd(RD, 32'h0);
    $display("wake test done");
    wr(WR, 32'h10000);
    rd(RD, 32'h0);
    rd(PW, 32'h6);
    chk({30'h0, pon}, 32'h3);
    wr(WR, 32'h0);
    rd(PW, 32'h6);
    wr(WR, 32'h1);
    rd(RD, 32'h0);
    rd(PW, 32'h0);
    chk({30'h0, pon}, 32'h0);
    $display("global power test done");
    wr(RHS_CTRL_ADDR, 32'h00040001);
    wr(WR, 32'h10000);
    rd(PW, 32'h2);
    pulse(1, 2'b11);
    pulse(2, 2'b01);
    rd(PW, 32'h6);
    wr(WR, 32'h1);
    rd(PW, 32'h4);
    chk({30'h0, pon}, 32'h2);
    pulse(2, 2'b10);
    rd(PW, 32'h0);
    wr(RHS_CTRL_ADDR, 32'h0);
    $display("per-port power test done");
    wr(RHS_IRQ_MASK_ADDR, 32'h3);
    @(posedge sys_clk) oc <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(RD, 32'h20002);
    chk({31'h0, irq}, 32'h1);
    rd(ST, 32'h1);
    rd(ST, 32'h0);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(WR, 32'h0);
    rd(RD, 32'h20002);
    wr(WR, 32'h20000);
    rd(RD, 32'h2);
    wr(RHS_CTRL_ADDR, 32'h2);
    rd(RD, 32'h20000);
    @(posedge sys_clk) oc <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(RHS_CTRL_ADDR, 32'h0);
    wr(WR, 32'h20000);
    rd(ST, 32'h1);
    rd(RD, 32'h0);
    @(posedge sys_clk) oc <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wr(WR, 32'h20000);
    @(posedge sys_clk) oc <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(RD, 32'h20000);
    rd(ST, 32'h1);
    $display("overcurrent test done");
    wr(WR, 32'h8000);
    @(posedge sys_clk) susp <= 1'b1;
    pulse(0, 2'b01);
    chk({31'h0, resume}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(ST, 32'h2);
    wr(WR, 32'h80000000);
    pulse(0, 2'b10);
    chk({31'h0, resume}, 32'h0);
    rd(ST, 32'h0);
    $display("resume test done");
    tally_and_finish();
  end
endmodule : tb

bind rhs_root_hub_status rhs_chk #(.NPORTS(NPORTS)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .overcurrent_in(overcurrent_in), .bus_suspended(bus_suspended),
  .port_attach_change(port_attach_change), .port_power_set(port_power_set),
  .port_power_clr(port_power_clr), .port_power_on(port_power_on),
  .resume_request(resume_request), .irq(irq));
